// >>> testbench/web_guide_status_image_bench.sv
module web_guide_status_image_bench;
   import wgs_pkg::*;
   timeunit 1ns / 1ps;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] rd_addr;
   logic [15:0] rd_data, app_page, guide_point;
   logic [1:0] pix_valid = 2'h0, pix_on = 2'h0, pix_last = 2'h0, image_done;
   logic [7:0] quality_s1, quality_s2, guide_flags, speed_pct, accel_pct, act_pitch, act_pos_pct;
   logic [6:0] act_stroke;
   logic [4:0] guide_modes, setting_flags;
   logic motor_pol_normal, width_mode, width_taught, filter_en;
   logic [31:0] width_raw, width_filt;
   logic [15:0] cov [2] = '{16'h0000, 16'h0000};
   logic [15:0] thr [2] = '{16'h0000, 16'h0000};
   logic [1:0] kinds [3] = '{2'h0, 2'h2, 2'h3};
   int seed = 7103;
   int n_mismatch = 0;
   int samples_checked = 0;
   always #2 clk = ~clk;
   wgs_status_image DUT (.*);
   wgs_plc_model plc (.clk(clk), .rd_data(rd_data), .rd_addr(rd_addr), .app_page(app_page));
   function automatic logic [7:0] pct(input logic [7:0] v);
      return (v > 8'h64) ? 8'h64 : v;
   endfunction
   function automatic logic [15:0] mean(input int s);
      return (thr[s] == 16'h0000) ? 16'h0000 : cov[s] / thr[s];
   endfunction
   function automatic logic [15:0] expect_word(input logic [3:0] a, input logic [15:0] p);
      logic [31:0] w;
      logic [7:0] pos;
      logic pg;
      w = !width_taught ? 32'h0 : filter_en ? width_filt : width_raw;
      pos = pct(act_pos_pct) | {!motor_pol_normal, 7'h00};
      pg = (p == 16'h0001);
      case (a)
         4'h4: return cov[0];
         4'h5: return cov[1];
         4'h6: return {quality_s1, quality_s2};
         4'h7: return {pct(speed_pct), pct(accel_pct)};
         4'h8: return {3'h0, guide_modes, guide_flags};
         4'h9: return guide_point;
         4'hA: return thr[0];
         4'hB: return thr[1];
         4'hC: return pg ? {2'h3, act_stroke[5:0], act_pitch} : 16'h0000;
         4'hD: return pg ? {2'h3, motor_pol_normal, setting_flags, pos} : 16'h0000;
         4'hE: return width_mode ? w[31:16] : mean(0);
         4'hF: return width_mode ? w[15:0] : mean(1);
         default: return 16'h0000;
      endcase
   endfunction
   task automatic check(input logic [3:0] a, input logic [15:0] p);
      logic [15:0] d;
      logic [15:0] e;
      e = expect_word(a, p);
      plc.read(a, p, d);
      samples_checked++;
      if (d !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: word %0d got %h want %h", $time, a, d, e);
      end
   endtask
   task automatic rand_levels();
      {quality_s1, quality_s2, guide_flags, speed_pct} = $random(seed);
      {accel_pct, act_pitch, act_pos_pct, act_stroke, motor_pol_normal} = $random(seed);
      {guide_point, guide_modes, setting_flags, width_mode, width_taught, filter_en} =
         29'($random(seed));
      width_raw = $random(seed);
      width_filt = $random(seed);
   endtask
   // Kind 0 draws pixels at random, kind 2 keeps both sensors dark, kind 3 fully covered.
   task automatic image(input int n, input logic [1:0] kind);
      logic [1:0] prev;
      prev = 2'h0;
      cov = '{16'h0000, 16'h0000};
      thr = '{16'h0000, 16'h0000};
      for (int i = 0; i < n; i++) begin
         pix_on = kind[1] ? {2{kind[0]}} : 2'($random(seed));
         pix_valid = 2'h3;
         pix_last = (i == n - 1) ? 2'h3 : 2'h0;
         for (int s = 0; s < 2; s++) begin
            cov[s] += pix_on[s];
            thr[s] += pix_on[s] & !prev[s];
         end
         prev = pix_on;
         @(posedge clk);
         #1;
      end
      pix_valid = 2'h0;
      pix_last = 2'h0;
      // The done pulse stands for the one cycle after the last pixel.
      samples_checked++;
      if (image_done !== 2'h3) begin
         n_mismatch++;
         $display("mismatch at %0t: image_done %b want 11", $time, image_done);
      end
      @(posedge clk);
      #1;
      samples_checked++;
      if (image_done !== 2'h0) begin
         n_mismatch++;
         $display("mismatch at %0t: image_done %b want 00", $time, image_done);
      end
      repeat (17) @(posedge clk);
      #1;
   endtask
   initial begin
      rand_levels();
      repeat (8) @(posedge clk);
      #1 reset_n = 1'b1;
      foreach (kinds[k]) begin
         image(40, kinds[k]);
         width_mode = 1'b0;
         for (int f = 0; f < 2; f++) begin
            filter_en = f[0];
            for (int a = 4; a < 16; a++)
               check(4'(a), 16'h0000);
         end
         $display("image test done");
      end
      for (int i = 0; i < 200; i++) begin
         rand_levels();
         check(4'($random(seed)), 16'(i % 3));
         check(4'hC, 16'h0001);
         check(4'hD, 16'h0001);
      end
      $display("register map test done");
      results();
   end
   initial begin
      #40000;
      n_mismatch++;
      results();
   end
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
endmodule
bind wgs_status_image wgs_status_image_assertions chk (.*);

// >>> testbench/wgs_plc_model.sv
module wgs_plc_model (
   input wire logic clk,
   input wire logic [15:0] rd_data,
   output logic [3:0] rd_addr,
   output logic [15:0] app_page
);
   timeunit 1ns / 1ps;
   initial begin
      rd_addr = 4'h0;
      app_page = 16'h0000;
   end
   // Address and page are held over the sampling edge; the word is taken just after it.
   task automatic read(input logic [3:0] a, input logic [15:0] p, output logic [15:0] d);
      rd_addr = a;
      app_page = p;
      @(posedge clk);
      #1 d = rd_data;
   endtask
endmodule

// >>> testbench/wgs_status_image_assertions.sv
module wgs_status_image_assertions
   import wgs_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] rd_addr,
   input wire logic [15:0] rd_data,
   input wire logic [15:0] app_page,
   input wire logic [7:0] quality_s1,
   input wire logic [7:0] quality_s2,
   input wire logic [7:0] guide_flags,
   input wire logic [4:0] guide_modes,
   input wire logic [15:0] guide_point,
   input wire logic [7:0] act_pitch,
   input wire logic [6:0] act_stroke,
   input wire logic motor_pol_normal,
   input wire logic [4:0] setting_flags,
   input wire logic width_mode,
   input wire logic width_taught,
   input wire logic filter_en,
   input wire logic [31:0] width_filt
);
   timeunit 1ns / 1ps;
   wire logic [15:0] wf_lo = width_filt[15:0];
   wire logic [5:0] st_lo = act_stroke[5:0];
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_quality_word: assert property (
      rd_addr == 4'h6 |=> rd_data == {$past(quality_s1), $past(quality_s2)}) else $error("quality");
   a_status_word: assert property (
      rd_addr == 4'h8 |=> rd_data == {3'h0, $past(guide_modes), $past(guide_flags)}) else $error("status");
   a_guide_point: assert property (
      rd_addr == 4'h9 |=> rd_data == $past(guide_point)) else $error("guide point");
   a_act_info: assert property (
      rd_addr == 4'hC && app_page == 16'h0001 |=> rd_data[15:14] == 2'h3
      && rd_data[13:0] == {$past(st_lo), $past(act_pitch)}) else $error("actuator info");
   a_page_refused: assert property (
      rd_addr == 4'hC && app_page != 16'h0001 |=> rd_data == 16'h0000) else $error("page");
   a_settings_word: assert property (
      rd_addr == 4'hD && app_page == 16'h0001 |=> rd_data[15:8]
      == {2'h3, $past(motor_pol_normal), $past(setting_flags)}) else $error("settings");
   a_width_untaught: assert property (
      rd_addr == 4'hE && width_mode && !width_taught |=> rd_data == 16'h0000) else $error("untaught");
   a_width_filtered: assert property (
      rd_addr == 4'hF && width_mode && width_taught && filter_en |=> rd_data == $past(wf_lo))
      else $error("filtered width");
endmodule

// >>> verilog/wgs_consts.svh
`ifndef WGS_CONSTS_SVH
`define WGS_CONSTS_SVH

// Word indices of the controller-output image.
`define WGS_W_COVER_S1 4'h4
`define WGS_W_COVER_S2 4'h5
`define WGS_W_QUALITY 4'h6
`define WGS_W_SPEED_ACCEL 4'h7
`define WGS_W_GUIDE_STATUS 4'h8
`define WGS_W_GUIDE_POINT 4'h9
`define WGS_W_THREADS_S1 4'hA
`define WGS_W_THREADS_S2 4'hB
`define WGS_W_ACT_INFO 4'hC
`define WGS_W_CTRL_SETTINGS 4'hD
`define WGS_W_WIDTH_HI 4'hE
`define WGS_W_WIDTH_LO 4'hF

// Paged words.
`define WGS_PAGE_ACTUATOR 16'h0001
`define WGS_PAGE_CONFIRM 2'h3

// Percent fields.
`define WGS_PCT_MAX 8'h64
`define WGS_POS_REVERSED_BASE 8'h80

// Field positions.
`define WGS_ST_HF_DISTURB 7
`define WGS_ST_MODE_LSB 8
`define WGS_ST_MODE_MSB 12
`define WGS_CS_MOTOR_POL 13
`define WGS_CS_FLAGS_LSB 8
`define WGS_CS_FLAGS_MSB 12

// Reset value of every image word.
`define WGS_WORD_RST 16'h0000

`endif

// >>> verilog/wgs_pkg.sv
package wgs_pkg;

   typedef logic [15:0] wgs_word_t;

   typedef enum logic {
      WGS_DIV_IDLE,
      WGS_DIV_BUSY
   } wgs_div_state_t;

endpackage

// >>> verilog/wgs_status_image.sv
`include "wgs_consts.svh"

module wgs_status_image
   import wgs_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input wire logic clk,
   input wire logic reset_n,
   // Word read port towards the fieldbus module.
   input wire logic [3:0] rd_addr,
   output logic [15:0] rd_data,
   // Controller-input word 7, written by the PLC.
   input wire logic [15:0] app_page,
   // Binary pixel streams of the two sensors, one pixel per valid cycle.
   input wire logic [1:0] pix_valid,
   input wire logic [1:0] pix_on,
   input wire logic [1:0] pix_last,
   input wire logic [7:0] quality_s1,
   input wire logic [7:0] quality_s2,
   input wire logic [7:0] guide_flags,
   input wire logic [4:0] guide_modes,
   input wire logic [15:0] guide_point,
   input wire logic [7:0] speed_pct,
   input wire logic [7:0] accel_pct,
   input wire logic [7:0] act_pitch,
   input wire logic [6:0] act_stroke,
   input wire logic [7:0] act_pos_pct,
   input wire logic motor_pol_normal,
   input wire logic [4:0] setting_flags,
   input wire logic width_mode,
   input wire logic width_taught,
   input wire logic filter_en,
   input wire logic [31:0] width_raw,
   input wire logic [31:0] width_filt,
   output logic [1:0] image_done
);

   if (CNT_W != 16) begin : g_check
      $error("wgs_status_image: CNT_W must be 16 to fill a 16-bit image word");
   end

   wgs_word_t cover_w [2];
   wgs_word_t threads_w [2];
   wgs_word_t mean_w [2];

   // Per-sensor image measurement: coverage, thread count and mean width.
   for (genvar s = 0; s < 2; s++) begin : g_sensor
      logic [CNT_W-1:0] cov_acc_r;
      logic [CNT_W-1:0] thr_acc_r;
      logic prev_on_r;
      logic [CNT_W-1:0] cov_r;
      logic [CNT_W-1:0] thr_r;
      logic done_r;
      wgs_div_state_t div_state_r;
      logic [4:0] div_cnt_r;
      logic [CNT_W:0] rem_r;
      logic [CNT_W-1:0] quo_r;
      logic [CNT_W-1:0] den_r;
      logic [CNT_W-1:0] mean_r;

      wire logic rising = pix_valid[s] & pix_on[s] & ~prev_on_r;
      wire logic [CNT_W-1:0] cov_nxt = cov_acc_r + {{(CNT_W-1){1'b0}}, pix_valid[s] & pix_on[s]};
      wire logic [CNT_W-1:0] thr_nxt = thr_acc_r + {{(CNT_W-1){1'b0}}, rising};
      wire logic frame_end = pix_valid[s] & pix_last[s];
      wire logic [CNT_W:0] rem_shift = {rem_r[CNT_W-1:0], quo_r[CNT_W-1]};
      wire logic rem_fits = rem_shift >= {1'b0, den_r};
      wire logic [CNT_W:0] rem_sub = rem_shift - {1'b0, den_r};
      wire logic [CNT_W-1:0] quo_step = {quo_r[CNT_W-2:0], rem_fits};

      // Each web adds its covered pixels; a rising edge starts a new web.
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            cov_acc_r <= '0;
            thr_acc_r <= '0;
            prev_on_r <= 1'b0;
         end else if (frame_end) begin
            cov_acc_r <= '0;
            thr_acc_r <= '0;
            prev_on_r <= 1'b0;
         end else if (pix_valid[s]) begin
            cov_acc_r <= cov_nxt;
            thr_acc_r <= thr_nxt;
            prev_on_r <= pix_on[s];
         end
      end

      // Results are latched at the last pixel, unfiltered.
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            cov_r <= '0;
            thr_r <= '0;
            done_r <= 1'b0;
         end else begin
            done_r <= frame_end;
            if (frame_end) begin
               cov_r <= cov_nxt;
               thr_r <= thr_nxt;
            end
         end
      end

      // Restoring divider: mean = coverage / threads; a new image restarts it.
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            div_state_r <= WGS_DIV_IDLE;
            div_cnt_r <= '0;
            rem_r <= '0;
            quo_r <= '0;
            den_r <= '0;
            mean_r <= '0;
         end else if (frame_end) begin
            div_state_r <= WGS_DIV_BUSY;
            div_cnt_r <= 5'h10;
            rem_r <= '0;
            quo_r <= cov_nxt;
            den_r <= thr_nxt;
         end else begin
            unique case (div_state_r)
               WGS_DIV_IDLE: begin
                  div_cnt_r <= '0;
               end
               WGS_DIV_BUSY: begin
                  rem_r <= rem_fits ? rem_sub : rem_shift;
                  quo_r <= quo_step;
                  div_cnt_r <= div_cnt_r - 5'h01;
                  if (div_cnt_r == 5'h01) begin
                     div_state_r <= WGS_DIV_IDLE;
                     mean_r <= (den_r == '0) ? '0 : quo_step;
                  end
               end
            endcase
         end
      end

      assign cover_w[s] = cov_r;
      assign threads_w[s] = thr_r;
      assign mean_w[s] = mean_r;
      assign image_done[s] = done_r;
   end

   // Percent fields are capped at 100; the position field adds 0x80 when motor polarity is reversed.
   wire logic [7:0] speed_sat = (speed_pct > `WGS_PCT_MAX) ? `WGS_PCT_MAX : speed_pct;
   wire logic [7:0] accel_sat = (accel_pct > `WGS_PCT_MAX) ? `WGS_PCT_MAX : accel_pct;
   wire logic [7:0] pos_sat = (act_pos_pct > `WGS_PCT_MAX) ? `WGS_PCT_MAX : act_pos_pct;
   wire logic [7:0] pos_field = motor_pol_normal ? pos_sat : pos_sat + `WGS_POS_REVERSED_BASE;

   wire logic page_ok = (app_page == `WGS_PAGE_ACTUATOR);

   wire wgs_word_t quality_word = {quality_s1, quality_s2};
   wire wgs_word_t speed_word = {speed_sat, accel_sat};
   wire wgs_word_t status_word = {3'h0, guide_modes, guide_flags};

   // Stroke bits 5:0 occupy bits 13:8; bits 15:14 are forced high as a page confirmation, over stroke bit 6.
   wire wgs_word_t act_info_raw = {1'b0, act_stroke, act_pitch};
   wire wgs_word_t act_info_word = page_ok ?
      (act_info_raw | {`WGS_PAGE_CONFIRM, 14'h0000}) : `WGS_WORD_RST;
   wire wgs_word_t settings_word = page_ok ?
      {`WGS_PAGE_CONFIRM, motor_pol_normal, setting_flags, pos_field} : `WGS_WORD_RST;

   // Width is taken as delivered: pixels with the taught compensation applied.
   wire logic [31:0] width_sel = filter_en ? width_filt : width_raw;
   wire logic [31:0] width_val = width_taught ? width_sel : 32'h0000_0000;
   wire wgs_word_t width_hi_word = width_mode ? width_val[31:16] : mean_w[0];
   wire wgs_word_t width_lo_word = width_mode ? width_val[15:0] : mean_w[1];

   logic [15:0] rd_mux;

   always_comb begin
      unique case (rd_addr)
         `WGS_W_COVER_S1: rd_mux = cover_w[0];
         `WGS_W_COVER_S2: rd_mux = cover_w[1];
         `WGS_W_QUALITY: rd_mux = quality_word;
         `WGS_W_SPEED_ACCEL: rd_mux = speed_word;
         `WGS_W_GUIDE_STATUS: rd_mux = status_word;
         `WGS_W_GUIDE_POINT: rd_mux = guide_point;
         `WGS_W_THREADS_S1: rd_mux = threads_w[0];
         `WGS_W_THREADS_S2: rd_mux = threads_w[1];
         `WGS_W_ACT_INFO: rd_mux = act_info_word;
         `WGS_W_CTRL_SETTINGS: rd_mux = settings_word;
         `WGS_W_WIDTH_HI: rd_mux = width_hi_word;
         `WGS_W_WIDTH_LO: rd_mux = width_lo_word;
         default: rd_mux = `WGS_WORD_RST;
      endcase
   end

   logic [15:0] rd_data_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data_r <= `WGS_WORD_RST;
      end else begin
         rd_data_r <= rd_mux;
      end
   end

   assign rd_data = rd_data_r;

endmodule
